/* hdl/csc_pkg.sv */
// Constants, types and field layout for the clock synthesizer control block.
// Function
// - Mode pin high at reset selects the synthesizer as system clock source.
// - Mode pin low at reset disables synthesizer; control bits are ignored.
// - Rate changes never disturb stored register contents.
// - Lock status bit readable in the synthesizer control register.
// - Chip held in reset until the synthesizer reports lock, or until the strap selects external mode.
// - Any comparator input change forces a new lock acquisition.
// - Doubler bit with speed bit clear doubles clock outside the loop with no relock.
// - Speed bit drives a 3-bit feedback prescaler, VCO four times faster with doubler clear.
// - Modulus field loads a modulo 64 down counter dividing by field+1.
// - Writes changing speed bit or modulus field start a relock interval.
// - System multiplier is 4 times (modulus+1) times (4^speed + doubler).
// - VCO multiplier is system multiplier times (2 minus doubler).
// - Reset value selects modulus 63, both prescaler bits clear, times 256.
// - Control register readable and writable at any time.
package csc_pkg;
   localparam int CTRL_W = 16;
   localparam int MOD_W = 6;
   localparam int MOD_LSB = 8;
   localparam int SPEED_BIT = 15;
   localparam int DBL_BIT = 14;
   localparam int LOCK_BIT = 3;
   localparam logic [15:0] CTRL_RESET = 16'h3F00;
   localparam logic [15:0] CTRL_WMASK = 16'hFFF7;
   localparam int MULT_W = 12;
   localparam int MULT_BASE = 4;
   localparam int PRESC_W = 3;
   // Lock time in microseconds, and its count at 40 MHz.
   localparam int CLK_MHZ = 40;
   localparam int LOCK_TIME_US = 20000;
   localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic speed;
      logic dbl;
      logic [MOD_W-1:0] modulus;
   } csc_ctrl_t;

   typedef struct packed {
      logic [MULT_W-1:0] sys_mult;
      logic [MULT_W-1:0] vco_mult;
   } csc_mult_t;
endpackage

/* hdl/csc_sync.sv */
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module csc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

/* hdl/csc_top.sv */
// Clock synthesizer control: mode strap, control register, lock sequencing.
`timescale 1ns/1ps
module csc_top #(
   parameter int LOCK_CYCLES = csc_pkg::LOCK_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pins
   input wire logic clock_source_select_pin,
   input wire logic reference_change,
   // Control register access
   input wire logic ctrl_wr,
   input wire logic [15:0] ctrl_wdata,
   output logic [15:0] synth_control_reg,
   // Status and clock settings
   output logic synth_lock_flag,
   output logic synth_enable,
   output logic chip_reset_hold,
   output csc_pkg::csc_ctrl_t synth_ctrl,
   output csc_pkg::csc_mult_t synth_mult
);
   localparam int CW = $clog2(LOCK_CYCLES + 1);
   localparam logic [CW-1:0] LOCK_LAST = CW'(LOCK_CYCLES - 1);
   localparam logic [CW-1:0] STRAP_LAST = CW'(csc_pkg::SYNC_STAGES);

   typedef enum logic [1:0] {
      CSC_STRAP,
      CSC_ACQUIRE,
      CSC_LOCKED,
      CSC_EXTERNAL
   } csc_state_t;

   csc_state_t state_q;
   csc_state_t state_d;
   logic mode_s;
   logic refchg_s;
   logic [15:0] ctrl_q;
   logic [15:0] ctrl_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic mode_q;
   logic hold_q;
   logic lock_q;

   ////////////////////////////////////////////////////////////////////////
   csc_sync #(.WIDTH(2)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .d({clock_source_select_pin, reference_change}),
      .q({mode_s, refchg_s})
   );

   ////////////////////////////////////////////////////////////////////////
   // Register decode and relock detection.
   wire [15:0] wr_val = ctrl_wdata & csc_pkg::CTRL_WMASK;
   wire speed_chg = ctrl_wr &&
      (wr_val[csc_pkg::SPEED_BIT] != ctrl_q[csc_pkg::SPEED_BIT]);
   wire [csc_pkg::MOD_W-1:0] mod_new =
      wr_val[csc_pkg::MOD_LSB +: csc_pkg::MOD_W];
   wire mod_chg = ctrl_wr &&
      (mod_new != ctrl_q[csc_pkg::MOD_LSB +: csc_pkg::MOD_W]);
   wire relock = mode_q && (speed_chg || mod_chg || refchg_s);
   wire cnt_done = (cnt_q == LOCK_LAST);

   // Writes land at any time; the doubler alone never restarts lock.
   assign ctrl_d = ctrl_wr ? wr_val : ctrl_q;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: strap catch after release, acquire, locked, external.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         CSC_STRAP: begin
            // The pin level needs the synchroniser depth to arrive.
            if (cnt_q == STRAP_LAST) begin
               cnt_d = '0;
               state_d = mode_s ? CSC_ACQUIRE : CSC_EXTERNAL;
            end else begin
               cnt_d = cnt_q + CW'(1);
            end
         end
         CSC_ACQUIRE: begin
            if (relock) begin
               cnt_d = '0;
            end else if (cnt_done) begin
               state_d = CSC_LOCKED;
            end else begin
               cnt_d = cnt_q + CW'(1);
            end
         end
         CSC_LOCKED: begin
            if (relock) begin
               cnt_d = '0;
               state_d = CSC_ACQUIRE;
            end
         end
         CSC_EXTERNAL: begin
            cnt_d = '0;
         end
         default: begin
            state_d = CSC_STRAP;
            cnt_d = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= CSC_STRAP;
         cnt_q <= '0;
         ctrl_q <= csc_pkg::CTRL_RESET;
         mode_q <= 1'b0;
         hold_q <= 1'b1;
         lock_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ctrl_q <= ctrl_d;
         if (state_q == CSC_STRAP) begin
            mode_q <= mode_s;
         end
         lock_q <= (state_d == CSC_LOCKED);
         if (state_d == CSC_LOCKED || state_d == CSC_EXTERNAL) begin
            hold_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frequency settings seen by the analogue loop.
   wire spd = ctrl_q[csc_pkg::SPEED_BIT];
   wire dbl = ctrl_q[csc_pkg::DBL_BIT];
   wire [csc_pkg::MOD_W-1:0] modv = ctrl_q[csc_pkg::MOD_LSB +: csc_pkg::MOD_W];
   // Feedback prescaler of 3 bits: 4^speed is 1 or 4.
   wire [csc_pkg::PRESC_W-1:0] presc = spd ? 3'h4 : 3'h1;
   wire [csc_pkg::MULT_W-1:0] div_fb =
      csc_pkg::MULT_W'({1'b0, modv} + 7'h01);
   wire [csc_pkg::MULT_W-1:0] pre_sum =
      csc_pkg::MULT_W'(presc) + csc_pkg::MULT_W'(dbl);
   wire [csc_pkg::MULT_W-1:0] sys_m =
      csc_pkg::MULT_W'(div_fb * pre_sum * csc_pkg::MULT_W'(csc_pkg::MULT_BASE));
   wire [csc_pkg::MULT_W-1:0] vco_m =
      dbl ? sys_m : csc_pkg::MULT_W'(sys_m << 1);

   assign synth_control_reg = {ctrl_q[15:4], lock_q, ctrl_q[2:0]};
   assign synth_lock_flag = lock_q;
   assign synth_enable = mode_q;
   assign chip_reset_hold = hold_q;
   // Outside synthesizer mode the control bits have no effect.
   assign synth_ctrl = mode_q ? {spd, dbl, modv} : '0;
   assign synth_mult = mode_q ? {sys_m, vco_m} : '0;
endmodule

/* verif/csc_props.sv */
// Assertions on the clock synthesizer control ports.
`timescale 1ns/1ps
module csc_props (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ctrl_wr,
   input wire logic [15:0] ctrl_wdata,
   input wire logic [15:0] synth_control_reg,
   input wire logic synth_lock_flag,
   input wire logic synth_enable,
   input wire logic chip_reset_hold,
   input wire csc_pkg::csc_ctrl_t synth_ctrl,
   input wire csc_pkg::csc_mult_t synth_mult
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire chg = |((ctrl_wdata ^ synth_control_reg) & 16'hBF00);
   wire [11:0] sys_e = 12'(4 * (synth_ctrl.modulus + 1)
      * ((synth_ctrl.speed ? 4 : 1) + synth_ctrl.dbl));
   AST_LOCK_BIT: assert property (synth_control_reg[3] == synth_lock_flag)
      else $error("lock bit");
   AST_WRITE: assert property (ctrl_wr |=> (synth_control_reg & 16'hFFF7)
      == ($past(ctrl_wdata) & 16'hFFF7)) else $error("write lost");
   AST_RELOCK: assert property (ctrl_wr && synth_enable && chg
      |=> !synth_lock_flag) else $error("no relock");
   AST_DOUBLER: assert property (ctrl_wr && synth_lock_flag && !chg
      |=> synth_lock_flag) else $error("doubler relock");
   AST_EXTERNAL: assert property (!synth_enable |-> synth_ctrl == 8'h00
      && synth_mult == 24'h000000) else $error("external outputs");
   AST_MULT: assert property (synth_enable && $past(synth_enable)
      && $stable(synth_ctrl) |-> synth_mult.sys_mult == sys_e
      && synth_mult.vco_mult == 12'(sys_e * (2 - synth_ctrl.dbl)))
      else $error("multiplier");
   AST_HOLD: assert property (synth_enable && chip_reset_hold
      && !synth_lock_flag |=> chip_reset_hold || synth_lock_flag)
      else $error("early release");
   AST_STRAP: assert property ($past(synth_enable) |-> synth_enable)
      else $error("mode lost");
endmodule

/* verif/csc_src_model.sv */
// Clock source model: mode strap and reference disturbances.
`timescale 1ns/1ps
module csc_src_model (
   input wire logic clk,
   input wire logic ext_mode,
   input wire logic bump,
   output logic clock_source_select_pin,
   output logic reference_change = 1'b0
);
   assign clock_source_select_pin = !ext_mode;
   always @(posedge clk) reference_change <= bump;
endmodule

/* verif/testbench.sv */
// Bench for the clock synthesizer control block.
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, nrst = 1'b0, ext = 1'b1, bump = 1'b0, wr = 1'b0;
   logic pin, rc, lk, en, hd;
   logic [15:0] wd = 16'h0000, ro;
   csc_pkg::csc_ctrl_t sc;
   csc_pkg::csc_mult_t mu;
   int fails = 0, check_count = 0, n;
   always #12.5 clk = ~clk;
   csc_src_model u_src (.clk, .ext_mode(ext), .bump,
      .clock_source_select_pin(pin), .reference_change(rc));
   csc_top #(.LOCK_CYCLES(16)) u_dut (.clk, .nrst, .reference_change(rc),
      .clock_source_select_pin(pin), .ctrl_wr(wr), .ctrl_wdata(wd),
      .synth_control_reg(ro), .synth_lock_flag(lk), .synth_enable(en),
      .chip_reset_hold(hd), .synth_ctrl(sc), .synth_mult(mu));
   task automatic cmp(input logic [23:0] g, e);
      check_count++;
      fails += int'(g !== e);
      if (g !== e) $display("BAD %0t %h %h", $time, g, e);
   endtask
   task automatic wr16(input logic [15:0] d);
      @(negedge clk) wd = d;
      wr = 1'b1;
      @(negedge clk) wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic wait_lk;
      for (n = 0; n < 99 && lk !== 1'b1; n++) @(negedge clk);
   endtask
   task automatic do_rst(input logic e);
      nrst = 1'b0;
      ext = e;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      repeat (5) @(negedge clk);
   endtask
   task automatic t_ext;
      do_rst(1'b1);
      wr16(16'h0100);
      cmp(24'({en, hd, ro & 16'hFFF7}), 24'h000100);
      cmp(mu | 24'(sc), 24'h000000);
      $display("ext mode done");
   endtask
   task automatic t_modes;
      logic [5:0] m;
      logic [11:0] s;
      do_rst(1'b0);
      wait_lk;
      cmp(24'({en, hd, ro & 16'hFFF7}), 24'h023F00);
      for (int k = 0; k < 4; k++) begin
         m = 6'(7'h7F >> (k == 0 ? 1 : k));
         s = 12'(4 * (m + 1) * ((k[1] ? 4 : 1) + k[0]));
         wr16({k[1:0], m, 8'h08});
         if (k == 1) cmp(24'(lk), 24'h000001);
         wait_lk;
         cmp(24'(ro & 16'hFFF7), 24'({k[1:0], m, 8'h00}));
         cmp(mu, {s, 12'(s * (2 - k[0]))});
      end
      $display("modes done");
   endtask
   task automatic t_relock;
      wr16(16'h3E00);
      cmp(24'(lk), 24'h000000);
      wait_lk;
      cmp(24'(n > 12 && n < 18), 24'h000001);
      @(negedge clk) bump = 1'b1;
      @(negedge clk) bump = 1'b0;
      repeat (4) @(negedge clk);
      cmp(24'({lk, ro & 16'hFFF7}), 24'h003E00);
      wait_lk;
      cmp(mu, {12'h0FC, 12'h1F8});
      $display("relock done");
   endtask
   task automatic print_verdict(input int hung);
      fails += hung;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial #100000 print_verdict(1);
   initial begin
      t_ext;
      t_modes;
      t_relock;
      print_verdict(0);
   end
endmodule
bind csc_top csc_props u_props (.clk, .nrst, .ctrl_wr, .ctrl_wdata,
   .synth_control_reg, .synth_lock_flag, .synth_enable, .chip_reset_hold,
   .synth_ctrl, .synth_mult);
